// *** hdl/cgdcd_blink_timer.sv ***
// toggles the cursor blink phase at a fixed interval while blinking is on
// assumes enable comes from logic on clk_sys
`timescale 1ns/100ps
module cgdcd_blink_timer #(
  parameter int PERIOD_CYCLES = cgdcd_pkg::BLINK_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic enable,
  output logic      phase
);

  logic [31:0] cnt_ff;
  logic        phase_ff;

  wire cnt_end = (cnt_ff == 32'(PERIOD_CYCLES - 1));

  // interval fixed to the system clock; it does not track an oscillator trim
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt_ff   <= 32'h0;
      phase_ff <= 1'b0;
    end else if (!enable) begin
      cnt_ff   <= 32'h0;
      phase_ff <= 1'b0;
    end else if (cnt_end) begin
      cnt_ff   <= 32'h0;
      phase_ff <= ~phase_ff;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  assign phase = phase_ff;

endmodule

// *** hdl/cgdcd_decoder.sv ***
// instruction decoder of a character/graphic display controller with its RAMs
// assumes host strobes from logic on clk_sys; mode straps are asynchronous pins
`timescale 1ns/100ps

module cgdcd_decoder #(
  parameter int POR_CYCLES   = cgdcd_pkg::POR_CYCLES,
  parameter int BLINK_CYCLES = cgdcd_pkg::BLINK_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire cgdcd_pkg::cgdcd_host_t host,
  input  wire logic                   graphic_mode_pin,
  input  wire logic                   panel_resolution_option_pin,
  input  wire logic [6:0]             scan_addr,
  output logic [7:0]                  rd_data,
  output logic                        busy_flag,
  output cgdcd_pkg::cgdcd_cfg_t       cfg,
  output logic [6:0]                  address_counter,
  output logic [1:0]                  graphic_page_select,
  output logic [6:0]                  display_shift,
  output cgdcd_pkg::cgdcd_duty_t      duty,
  output logic [3:0]                  cursor_row,
  output logic                        panel_blank,
  output logic                        cursor_blank,
  output logic                        split_mode,
  output logic [5:0]                  line2_com_start,
  output logic [7:0]                  scan_char
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] text_step(input logic [6:0] a, input logic up,
                                           input logic two);
    if (two) begin
      if (up) return (a == cgdcd_pkg::LAST_LINE1_2L) ? cgdcd_pkg::LINE2_BASE :
                     (a == cgdcd_pkg::LAST_LINE2) ? 7'h00 : 7'(a + 7'h01);
      return (a == 7'h00) ? cgdcd_pkg::LAST_LINE2 :
             (a == cgdcd_pkg::LINE2_BASE) ? cgdcd_pkg::LAST_LINE1_2L : 7'(a - 7'h01);
    end
    if (up) return (a == cgdcd_pkg::LAST_1L) ? 7'h00 : 7'(a + 7'h01);
    return (a == 7'h00) ? cgdcd_pkg::LAST_1L : 7'(a - 7'h01);
  endfunction

  // offset counts left shifts modulo the line length; both lines move together
  function automatic logic [6:0] shift_step(input logic [6:0] s, input logic left,
                                            input logic two);
    logic [6:0] last;
    last = two ? 7'(cgdcd_pkg::LINE_LEN_2 - 7'h01) : 7'(cgdcd_pkg::LINE_LEN_1 - 7'h01);
    if (left) return (s >= last) ? 7'h00 : 7'(s + 7'h01);
    return (s == 7'h00 || s > last) ? last : 7'(s - 7'h01);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cgdcd_pkg::cgdcd_state_t state_ff, nxt_state;
  cgdcd_pkg::cgdcd_tgt_t   tgt_ff, nxt_tgt;
  cgdcd_pkg::cgdcd_cfg_t   cfg_ff, nxt_cfg;
  cgdcd_pkg::cgdcd_duty_t  duty_ff;
  cgdcd_pkg::cgdcd_host_t  byte_in;
  logic [31:0] por_cnt_ff, nxt_por_cnt;
  logic [6:0]  clr_idx_ff, nxt_clr_idx;
  logic [6:0]  ac_ff, nxt_ac;
  logic [1:0]  page_ff, nxt_page;
  logic [6:0]  shift_ff, nxt_shift;
  logic        setup_done_ff, nxt_setup_done;
  logic        busy_ff;
  logic [7:0]  rd_data_ff;
  logic [7:0]  rd_byte_ff;
  logic        gfx_meta_ff, gfx_ff;
  logic        panel_resolution_option_meta_ff, panel_resolution_option_ff;
  logic [3:0]  cursor_row_ff;
  logic        panel_blank_ff;
  logic        cursor_blank_ff;
  logic        split_ff;
  logic [5:0]  line2_com_ff;
  logic [7:0]  scan_char_ff;
  logic        rd_low;
  logic        blink_phase;

  logic [7:0] txt_ram   [cgdcd_pkg::LINE_LEN_1];
  logic [7:0] glyph_ram [cgdcd_pkg::GLYPH_DEPTH];
  logic [7:0] gfx_ram   [cgdcd_pkg::GFX_DEPTH];

  cgdcd_nibble_join u_nibble (
    .clk_sys          (clk_sys),
    .reset_n          (reset_n),
    .host             (host),
    .bus_width_select (cfg_ff.bus_width_select),
    .byte_out         (byte_in),
    .rd_low           (rd_low)
  );

  cgdcd_blink_timer #(.PERIOD_CYCLES(BLINK_CYCLES)) u_blink (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .enable  (cfg_ff.blink_on),
    .phase   (blink_phase)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [7:0] d       = byte_in.data;
  wire       idle    = (state_ff == cgdcd_pkg::ST_IDLE);
  // busy drops instructions and data accesses
  wire       cmd_ok  = byte_in.wr & ~byte_in.register_select & idle;
  wire       data_wr = byte_in.wr & byte_in.register_select & idle;
  wire       data_rd = byte_in.rd & byte_in.register_select & idle;
  wire       op_addr = cmd_ok & d[7];
  wire       op_cg   = cmd_ok & (d[7:6] == 2'b01);
  wire       op_fn   = cmd_ok & (d[7:5] == 3'b001);
  wire       op_sh   = cmd_ok & (d[7:4] == 4'b0001);
  wire       op_dc   = cmd_ok & (d[7:3] == 5'b00001);
  wire       op_em   = cmd_ok & (d[7:2] == 6'b000001);
  wire       op_home = cmd_ok & (d[7:1] == 7'b0000001);
  wire       op_clr  = cmd_ok & (d == 8'h01);
  wire       clr_end = (state_ff == cgdcd_pkg::ST_CLEAR) &&
                       (clr_idx_ff == 7'(cgdcd_pkg::LINE_LEN_1 - 7'h01));
  // after setup, function set only acts when it changes the width
  wire       fn_ok   = ~setup_done_ff | (d[cgdcd_pkg::FS_BUS_BIT] != cfg_ff.bus_width_select);

  wire [6:0] txt_idx = (cfg_ff.two_line && ac_ff[6]) ?
                       7'(cgdcd_pkg::LINE_LEN_2 + {1'b0, ac_ff[5:0]}) : ac_ff;
  wire       txt_ok  = (txt_idx < cgdcd_pkg::LINE_LEN_1);
  wire [8:0] gfx_idx = 9'(9'(page_ff) * cgdcd_pkg::GFX_COLS + {2'b00, ac_ff});
  wire       gfx_ok  = (ac_ff <= cgdcd_pkg::GFX_LAST_COL);
  wire       clearing = (state_ff == cgdcd_pkg::ST_CLEAR);
  wire       txt_we  = clearing | (data_wr & (tgt_ff == cgdcd_pkg::TGT_TEXT) & txt_ok);
  wire [6:0] txt_widx = clearing ? clr_idx_ff : txt_idx;
  wire [7:0] txt_wdat = clearing ? cgdcd_pkg::SPACE_CODE : d;
  wire       glyph_we = data_wr & (tgt_ff == cgdcd_pkg::TGT_GLYPH);
  wire       gfx_we   = data_wr & (tgt_ff == cgdcd_pkg::TGT_GFX) & gfx_ok;

  wire [7:0] txt_rd   = txt_ok ? txt_ram[txt_idx] : 8'h00;
  wire [7:0] gfx_rd   = gfx_ok ? gfx_ram[gfx_idx] : 8'h00;
  wire [7:0] ram_rd   = (tgt_ff == cgdcd_pkg::TGT_TEXT)  ? txt_rd :
                        (tgt_ff == cgdcd_pkg::TGT_GLYPH) ? glyph_ram[ac_ff[5:0]] : gfx_rd;
  wire [7:0] rd_sel   = byte_in.register_select ? ram_rd : {busy_ff, ac_ff};

  wire cgdcd_pkg::cgdcd_duty_t duty_sel =
    ~panel_resolution_option_ff ? (cfg_ff.two_line ? cgdcd_pkg::DUTY_1_16 :
                 cfg_ff.font_5x10 ? cgdcd_pkg::DUTY_1_11 : cgdcd_pkg::DUTY_1_8) :
    (~cfg_ff.two_line & cfg_ff.font_5x10) ? cgdcd_pkg::DUTY_1_22 : cgdcd_pkg::DUTY_1_32;
  wire [6:0] scan_idx = (scan_addr < cgdcd_pkg::LINE_LEN_1) ? scan_addr : 7'h00;

  // ---------------------------------------------------------------
  // sequencer: power-on wait, then clear sweep
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state   = state_ff;
    nxt_por_cnt = por_cnt_ff;
    nxt_clr_idx = clr_idx_ff;
    case (state_ff)
      cgdcd_pkg::ST_POR: begin
        nxt_por_cnt = 32'(por_cnt_ff + 32'h1);
        if (por_cnt_ff >= 32'(POR_CYCLES - 1)) begin
          nxt_state   = cgdcd_pkg::ST_CLEAR;
          nxt_clr_idx = 7'h00;
        end
      end
      cgdcd_pkg::ST_CLEAR: begin
        nxt_clr_idx = 7'(clr_idx_ff + 7'h01);
        if (clr_end) begin
          nxt_state = cgdcd_pkg::ST_IDLE;
        end
      end
      cgdcd_pkg::ST_IDLE: begin
        if (op_clr) begin
          nxt_state   = cgdcd_pkg::ST_CLEAR;
          nxt_clr_idx = 7'h00;
        end
      end
      default: nxt_state = cgdcd_pkg::ST_POR;
    endcase
  end

  // ---------------------------------------------------------------
  // command execution
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cfg        = cfg_ff;
    nxt_ac         = ac_ff;
    nxt_page       = page_ff;
    nxt_tgt        = tgt_ff;
    nxt_shift      = shift_ff;
    nxt_setup_done = setup_done_ff;
    if (clr_end) begin
      nxt_ac            = 7'h00;
      nxt_shift         = 7'h00;
      nxt_tgt           = cgdcd_pkg::TGT_TEXT;
      nxt_cfg.entry_inc = 1'b1;
    end else if (cmd_ok) begin
      if (!op_fn) begin
        nxt_setup_done = 1'b1;
      end
      if (op_addr) begin
        nxt_ac  = d[6:0];
        nxt_tgt = gfx_ff ? cgdcd_pkg::TGT_GFX : cgdcd_pkg::TGT_TEXT;
      end else if (op_cg) begin
        if (gfx_ff) begin
          nxt_page = d[1:0];
          nxt_tgt  = cgdcd_pkg::TGT_GFX;
        end else begin
          nxt_ac  = {1'b0, d[5:0]};
          nxt_tgt = cgdcd_pkg::TGT_GLYPH;
        end
      end else if (op_fn) begin
        if (fn_ok) begin
          nxt_cfg.bus_width_select = d[cgdcd_pkg::FS_BUS_BIT];
          nxt_cfg.two_line         = d[cgdcd_pkg::FS_LINES_BIT];
          nxt_cfg.font_5x10        = d[cgdcd_pkg::FS_FONT_BIT];
        end
      end else if (op_sh) begin
        if (d[cgdcd_pkg::SH_SEL_BIT]) begin
          nxt_shift = shift_step(shift_ff, ~d[cgdcd_pkg::SH_DIR_BIT], cfg_ff.two_line);
        end else if (!gfx_ff) begin
          nxt_ac  = text_step(ac_ff, d[cgdcd_pkg::SH_DIR_BIT], cfg_ff.two_line);
          nxt_tgt = cgdcd_pkg::TGT_TEXT;
        end
      end else if (op_dc) begin
        nxt_cfg.display_on = d[cgdcd_pkg::DC_DISP_BIT];
        nxt_cfg.cursor_on  = d[cgdcd_pkg::DC_CURS_BIT];
        nxt_cfg.blink_on   = d[cgdcd_pkg::DC_BLINK_BIT];
      end else if (op_em) begin
        nxt_cfg.entry_inc  = d[cgdcd_pkg::EM_DIR_BIT];
        nxt_cfg.auto_shift = d[cgdcd_pkg::EM_SHIFT_BIT];
      end else if (op_home) begin
        nxt_ac    = 7'h00;
        nxt_shift = 7'h00;
        nxt_tgt   = cgdcd_pkg::TGT_TEXT;
      end
    end else if (data_wr || data_rd) begin
      nxt_setup_done = 1'b1;
      case (tgt_ff)
        cgdcd_pkg::TGT_TEXT: begin
          nxt_ac = text_step(ac_ff, cfg_ff.entry_inc, cfg_ff.two_line);
          if (data_wr && cfg_ff.auto_shift) begin
            nxt_shift = shift_step(shift_ff, cfg_ff.entry_inc, cfg_ff.two_line);
          end
        end
        cgdcd_pkg::TGT_GLYPH: begin
          nxt_ac = {1'b0, cfg_ff.entry_inc ? 6'(ac_ff[5:0] + 6'h01) : 6'(ac_ff[5:0] - 6'h01)};
        end
        cgdcd_pkg::TGT_GFX: begin
          nxt_ac = (ac_ff < cgdcd_pkg::GFX_LAST_COL) ? 7'(ac_ff + 7'h01) : ac_ff;
        end
        default: nxt_tgt = cgdcd_pkg::TGT_TEXT;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_ff      <= cgdcd_pkg::ST_POR;
      por_cnt_ff    <= 32'h0;
      clr_idx_ff    <= 7'h00;
      cfg_ff        <= cgdcd_pkg::CFG_RST;
      ac_ff         <= 7'h00;
      page_ff       <= 2'h0;
      tgt_ff        <= cgdcd_pkg::TGT_TEXT;
      shift_ff      <= 7'h00;
      setup_done_ff <= 1'b0;
      busy_ff       <= 1'b1;
    end else begin
      state_ff      <= nxt_state;
      por_cnt_ff    <= nxt_por_cnt;
      clr_idx_ff    <= nxt_clr_idx;
      cfg_ff        <= nxt_cfg;
      ac_ff         <= nxt_ac;
      page_ff       <= nxt_page;
      tgt_ff        <= nxt_tgt;
      shift_ff      <= nxt_shift;
      setup_done_ff <= nxt_setup_done;
      busy_ff       <= (nxt_state != cgdcd_pkg::ST_IDLE);
    end
  end

  // straps are asynchronous pins, so two stages before use
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gfx_meta_ff   <= 1'b0;
      gfx_ff        <= 1'b0;
      panel_resolution_option_meta_ff <= 1'b0;
      panel_resolution_option_ff      <= 1'b0;
    end else begin
      gfx_meta_ff   <= graphic_mode_pin;
      gfx_ff        <= gfx_meta_ff;
      panel_resolution_option_meta_ff <= panel_resolution_option_pin;
      panel_resolution_option_ff      <= panel_resolution_option_meta_ff;
    end
  end

  // second half of a 4-bit read returns the low nibble on the upper lines
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rd_data_ff <= 8'h00;
      rd_byte_ff <= 8'h00;
    end else if (byte_in.rd) begin
      rd_data_ff <= rd_sel;
      rd_byte_ff <= rd_sel;
    end else if (rd_low) begin
      rd_data_ff <= {rd_byte_ff[3:0], 4'h0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      duty_ff         <= cgdcd_pkg::DUTY_1_8;
      cursor_row_ff   <= cgdcd_pkg::CURSOR_ROW_5X8;
      panel_blank_ff  <= 1'b1;
      cursor_blank_ff <= 1'b0;
      split_ff        <= 1'b0;
      line2_com_ff    <= cgdcd_pkg::LINE1_COM;
      scan_char_ff    <= 8'h00;
    end else begin
      duty_ff         <= duty_sel;
      cursor_row_ff   <= cfg_ff.font_5x10 ? cgdcd_pkg::CURSOR_ROW_5X10 :
                                            cgdcd_pkg::CURSOR_ROW_5X8;
      panel_blank_ff  <= ~cfg_ff.display_on;
      cursor_blank_ff <= cfg_ff.blink_on & blink_phase;
      split_ff        <= panel_resolution_option_ff & ~cfg_ff.two_line;
      line2_com_ff    <= (panel_resolution_option_ff & ~cfg_ff.two_line) ? cgdcd_pkg::SPLIT_LINE2_COM :
                                                          cgdcd_pkg::LINE1_COM;
      scan_char_ff    <= txt_ram[scan_idx];
    end
  end

  // memories carry no reset; text is swept to spaces after reset instead
  always_ff @(posedge clk_sys) begin
    if (txt_we) begin
      txt_ram[txt_widx] <= txt_wdat;
    end
    if (glyph_we) begin
      glyph_ram[ac_ff[5:0]] <= d;
    end
    if (gfx_we) begin
      gfx_ram[gfx_idx] <= d;
    end
  end

  assign rd_data             = rd_data_ff;
  assign busy_flag           = busy_ff;
  assign cfg                 = cfg_ff;
  assign address_counter     = ac_ff;
  assign graphic_page_select = page_ff;
  assign display_shift       = shift_ff;
  assign duty                = duty_ff;
  assign cursor_row          = cursor_row_ff;
  assign panel_blank         = panel_blank_ff;
  assign cursor_blank        = cursor_blank_ff;
  assign split_mode          = split_ff;
  assign line2_com_start     = line2_com_ff;
  assign scan_char           = scan_char_ff;

endmodule

// *** hdl/cgdcd_nibble_join.sv ***
// joins two 4-bit host transfers into one byte, or passes 8-bit transfers
// assumes host strobes are one-cycle pulses from logic on clk_sys
`timescale 1ns/100ps
module cgdcd_nibble_join (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire cgdcd_pkg::cgdcd_host_t host,
  input  wire logic               bus_width_select,
  output cgdcd_pkg::cgdcd_host_t  byte_out,
  output logic                    rd_low
);

  logic [3:0]             hi_ff;
  logic                   wr_half_ff;
  logic                   rd_half_ff;
  cgdcd_pkg::cgdcd_host_t byte_ff;
  logic                   rd_low_ff;

  // ---------------------------------------------------------------
  // pairing
  // ---------------------------------------------------------------
  wire wr_done   = host.wr & (bus_width_select | wr_half_ff);
  wire rd_first  = host.rd & (bus_width_select | ~rd_half_ff);
  wire rd_second = host.rd & ~bus_width_select & rd_half_ff;
  // only the upper four lines carry data in 4-bit mode
  wire [7:0] joined = bus_width_select ? host.data : {hi_ff, host.data[7:4]};

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hi_ff      <= 4'h0;
      wr_half_ff <= 1'b0;
      rd_half_ff <= 1'b0;
      byte_ff    <= '0;
      rd_low_ff  <= 1'b0;
    end else begin
      byte_ff.wr              <= wr_done;
      byte_ff.rd              <= rd_first;
      byte_ff.register_select <= host.register_select;
      byte_ff.data            <= joined;
      rd_low_ff               <= rd_second;
      // width change drops any half-finished pair
      if (bus_width_select) begin
        wr_half_ff <= 1'b0;
        rd_half_ff <= 1'b0;
      end else begin
        if (host.wr) begin
          wr_half_ff <= ~wr_half_ff;
          hi_ff      <= host.data[7:4];
        end
        if (host.rd) begin
          rd_half_ff <= ~rd_half_ff;
        end
      end
    end
  end

  assign byte_out = byte_ff;
  assign rd_low   = rd_low_ff;

endmodule

// *** hdl/cgdcd_pkg.sv ***
// constants, enumerations and carrier structs of the display command decoder
// assumes a 100 MHz system clock; shared by the decoder and its helper modules
package cgdcd_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_TIME_US   = 10000;
  localparam int POR_CYCLES    = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_TIME_US = 409600;
  localparam int BLINK_CYCLES  = (BLINK_TIME_US * 1000) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // addresses and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] SPACE_CODE       = 8'h20;
  localparam logic [6:0] LINE_LEN_1       = 7'h50;
  localparam logic [6:0] LINE_LEN_2       = 7'h28;
  localparam logic [6:0] LAST_1L          = 7'h4F;
  localparam logic [6:0] LAST_LINE1_2L    = 7'h27;
  localparam logic [6:0] LINE2_BASE       = 7'h40;
  localparam logic [6:0] LAST_LINE2       = 7'h67;
  localparam logic [6:0] GFX_LAST_COL     = 7'h63;
  localparam logic [8:0] GFX_COLS         = 9'h064;
  localparam int         GFX_DEPTH        = 400;
  localparam int         GLYPH_DEPTH      = 64;
  localparam logic [6:0] SPLIT_LINE2_ADDR = 7'h14;
  localparam logic [5:0] LINE1_COM        = 6'h01;
  localparam logic [5:0] SPLIT_LINE2_COM  = 6'h11;
  localparam logic [3:0] CURSOR_ROW_5X8   = 4'h8;
  localparam logic [3:0] CURSOR_ROW_5X10  = 4'hB;

  // ---------------------------------------------------------------
  // command field positions
  // ---------------------------------------------------------------
  localparam int FS_BUS_BIT   = 4;
  localparam int FS_LINES_BIT = 3;
  localparam int FS_FONT_BIT  = 2;
  localparam int SH_SEL_BIT   = 3;
  localparam int SH_DIR_BIT   = 2;
  localparam int DC_DISP_BIT  = 2;
  localparam int DC_CURS_BIT  = 1;
  localparam int DC_BLINK_BIT = 0;
  localparam int EM_DIR_BIT   = 1;
  localparam int EM_SHIFT_BIT = 0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_POR, ST_CLEAR, ST_IDLE} cgdcd_state_t;
  typedef enum logic [1:0] {TGT_TEXT, TGT_GLYPH, TGT_GFX} cgdcd_tgt_t;
  typedef enum logic [2:0] {DUTY_1_8, DUTY_1_11, DUTY_1_16, DUTY_1_22, DUTY_1_32} cgdcd_duty_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       register_select;
    logic [7:0] data;
  } cgdcd_host_t;

  typedef struct packed {
    logic display_on;
    logic cursor_on;
    logic blink_on;
    logic entry_inc;
    logic auto_shift;
    logic two_line;
    logic font_5x10;
    logic bus_width_select;
  } cgdcd_cfg_t;

  localparam cgdcd_cfg_t CFG_RST = '{display_on: 1'b0, cursor_on: 1'b0, blink_on: 1'b0,
                                     entry_inc: 1'b1, auto_shift: 1'b0, two_line: 1'b0,
                                     font_5x10: 1'b0, bus_width_select: 1'b1};

endpackage

// *** tb/cgdcd_decoder_sva.sv ***
// port checker for the display command decoder
// assumes the bind at the foot of this file
`timescale 1ns/100ps
module cgdcd_decoder_sva (
  input wire logic                   clk_sys,
  input wire logic                   reset_n,
  input wire cgdcd_pkg::cgdcd_host_t host,
  input wire logic                   busy_flag,
  input wire cgdcd_pkg::cgdcd_cfg_t  cfg,
  input wire logic [6:0]             address_counter,
  input wire logic [6:0]             display_shift,
  input wire cgdcd_pkg::cgdcd_duty_t duty,
  input wire logic [3:0]             cursor_row,
  input wire logic                   panel_blank,
  input wire logic                   cursor_blank,
  input wire logic                   split_mode,
  input wire logic [5:0]             line2_com_start
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic ok;
  // only whole 8-bit bytes taken while idle
  assign ok = host.wr && !host.register_select && !busy_flag && cfg.bus_width_select;
  clr_busy_a: assert property (ok && host.data == 8'h01 |-> ##2 busy_flag)
    else $error("clear left busy low");
  clr_end_a: assert property ($fell(busy_flag) |-> address_counter == 7'h00
    && display_shift == 7'h00 && cfg.entry_inc) else $error("clear end state wrong");
  home_a: assert property (ok && host.data[7:1] == 7'h01 |-> ##2
    address_counter == 7'h00 && display_shift == 7'h00) else $error("home wrong");
  blank_a: assert property ($stable(cfg) |-> panel_blank == !cfg.display_on)
    else $error("blank wrong");
  row_a: assert property ($stable(cfg) |-> cursor_row == (cfg.font_5x10 ? 4'hB : 4'h8))
    else $error("cursor row wrong");
  blink_off_a: assert property ($stable(cfg) && !cfg.blink_on |-> !cursor_blank)
    else $error("blink while off");
  duty_a: assert property ($stable(cfg) && !split_mode && !cfg.two_line |->
    duty == (cfg.font_5x10 ? cgdcd_pkg::DUTY_1_11 : cgdcd_pkg::DUTY_1_8)) else $error("duty");
  split_com_a: assert property ($stable(split_mode) |->
    line2_com_start == (split_mode ? 6'h11 : 6'h01)) else $error("second group start wrong");
  cover property ($fell(busy_flag));
  cover property (split_mode);
  cover property (ok && host.data == 8'h01);
endmodule
bind cgdcd_decoder cgdcd_decoder_sva cgdcd_decoder_sva_i (.clk_sys, .reset_n, .host, .busy_flag,
  .cfg, .address_counter, .display_shift, .duty, .cursor_row, .panel_blank, .cursor_blank,
  .split_mode, .line2_com_start);

// *** tb/cgdcd_decoder_tb.sv ***
// self-checking bench for the display command decoder
// assumes the host model drives the host port
`timescale 1ns/100ps
module cgdcd_decoder_tb;
  logic                   clk_sys, reset_n, res_pin, gfx_pin, busy_flag, panel_blank;
  logic                   cursor_blank, split_mode;
  logic [7:0]             rd_data, scan_char;
  logic [6:0]             address_counter, display_shift;
  logic [5:0]             line2_com_start;
  logic [3:0]             cursor_row;
  logic [1:0]             graphic_page_select;
  cgdcd_pkg::cgdcd_host_t host;
  cgdcd_pkg::cgdcd_cfg_t  cfg;
  cgdcd_pkg::cgdcd_duty_t duty;
  int                     fails = 0, checks = 0, cyc = 0;
  cgdcd_host_model cgdcd_host_model_i (.clk_sys, .host);
  cgdcd_decoder #(.POR_CYCLES(20), .BLINK_CYCLES(16)) cgdcd_decoder_i (.clk_sys, .reset_n, .host,
    .graphic_mode_pin(gfx_pin), .panel_resolution_option_pin(res_pin), .scan_addr(7'h27), .rd_data,
    .busy_flag, .cfg, .address_counter, .graphic_page_select, .display_shift, .duty, .cursor_row,
    .panel_blank, .cursor_blank, .split_mode, .line2_com_start, .scan_char);
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmd(input logic rd, input logic rs, input logic [7:0] d);
    cgdcd_host_model_i.xfer(rd, rs, d);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic idle;
    int n = 0;
    while (busy_flag !== 1'b0 && n < 200) begin
      @(posedge clk_sys) #1;
      n++;
    end
    chk("idle", busy_flag, 8'h00);
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    reset_n = 1'b0;
    res_pin = 1'b0;
    gfx_pin = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    chk("busy", busy_flag, 8'h01);
    chk("cfg", cfg, cgdcd_pkg::CFG_RST);
    chk("page", graphic_page_select, 8'h00);
    idle;
    $display("test reset done");
    cmd(0, 0, 8'h38);
    chk("duty", duty, cgdcd_pkg::DUTY_1_16);
    cmd(0, 0, 8'h0F);
    chk("blank", panel_blank, 8'h00);
    repeat (15) @(posedge clk_sys);
    #1 chk("blink low", cursor_blank, 8'h00);
    @(posedge clk_sys) #1 chk("blink high", cursor_blank, 8'h01);
    cmd(0, 0, 8'h07);
    cmd(0, 0, 8'hA7);
    cmd(0, 1, 8'h41);
    chk("line wrap", address_counter, 8'h40);
    chk("auto shift", display_shift, 8'h01);
    cmd(1, 1, 8'h00);
    chk("read shift", display_shift, 8'h01);
    cmd(0, 0, 8'h10);
    chk("cursor left", address_counter, 8'h40);
    cmd(0, 0, 8'h18);
    chk("display left", {address_counter, display_shift == 7'h02}, 8'h81);
    cmd(1, 0, 8'h00);
    chk("status", rd_data, 8'h40);
    cmd(0, 0, 8'h03);
    chk("home", {address_counter, display_shift == 7'h00}, 8'h01);
    $display("test shifts done");
    chk("ram", scan_char, 8'h41);
    cmd(0, 0, 8'h05);
    cmd(0, 0, 8'hC5);
    cmd(0, 1, 8'h42);
    chk("decrement", address_counter, 8'h44);
    chk("shift right", display_shift, 8'h27);
    cmd(0, 0, 8'h01);
    chk("clear busy", busy_flag, 8'h01);
    idle;
    chk("clear ram", scan_char, 8'h20);
    chk("clear entry", {cfg.entry_inc, cfg.auto_shift}, 8'h03);
    cmd(0, 0, 8'h7F);
    chk("glyph ac", address_counter, 8'h3F);
    cmd(0, 1, 8'h1F);
    chk("glyph step", {address_counter, display_shift == 7'h00}, 8'h01);
    gfx_pin = 1'b1;
    cmd(0, 0, 8'h42);
    chk("page set", graphic_page_select, 8'h02);
    cmd(0, 0, 8'hE2);
    cmd(0, 1, 8'hAA);
    cmd(0, 1, 8'h55);
    chk("column stop", address_counter, 8'h63);
    cmd(0, 0, 8'hE2);
    cmd(1, 1, 8'h00);
    chk("gfx read", rd_data, 8'hAA);
    chk("column step", address_counter, 8'h63);
    res_pin = 1'b1;
    cmd(0, 0, 8'h24);
    chk("split", {split_mode, line2_com_start}, 8'h51);
    chk("row", cursor_row, 8'h0B);
    chk("duty split", duty, cgdcd_pkg::DUTY_1_22);
    cmd(0, 0, 8'h00);
    cmd(0, 0, 8'h80);
    chk("nibble pair", panel_blank, 8'h01);
    cmd(1, 0, 8'h00);
    chk("read high", rd_data[7:4], 8'h06);
    cmd(1, 0, 8'h00);
    chk("read low", rd_data[7:4], 8'h03);
    $display("test modes done");
    complete_run;
  end
endmodule

// *** tb/cgdcd_host_model.sv ***
// host side model: one-cycle strobes on the decoder host port
// assumes clk_sys from the bench
`timescale 1ns/100ps
module cgdcd_host_model (
  input wire logic                clk_sys,
  output cgdcd_pkg::cgdcd_host_t  host
);
  initial host = '0;
  // 4-bit bytes go as two calls, high nibble first
  task automatic xfer(input logic rd, input logic rs, input logic [7:0] d);
    @(posedge clk_sys) #1;
    host = '{!rd, rd, rs, d};
    @(posedge clk_sys) #1;
    host = '{1'b0, 1'b0, rs, ~d};
  endtask
endmodule
